/* File: pcm_channel.v */
// one capture/compare module: match detect, toggle, pulse width and frequency output
`timescale 1ns/1ps
`include "pcm_consts.vh"
module pcm_channel
(
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // timebase
  input  wire        tick,
  input  wire [15:0] count,
  // configuration
  input  wire [15:0] compare,
  input  wire [7:0]  mode,
  input  wire        enable,
  // results
  output wire        match,
  output reg         pin
);

  reg  [7:0] freq_point;
  wire       comp_on = enable & mode[`PCM_MODE_COMP];
  wire       pwm     = mode[`PCM_MODE_PWM];
  wire       tog     = mode[`PCM_MODE_TOGGLE];
  wire       wide    = mode[`PCM_MODE_WIDE];
  wire       freq    = pwm & tog;
  wire       low_eq  = count[7:0] == compare[7:0];
  wire       full_eq = count == compare;
  wire       freq_eq = count[7:0] == freq_point;

  // nothing compares unless the comparator is on [R9]
  assign match = comp_on & tick & (freq ? freq_eq : ((pwm & !wide) ? low_eq : full_eq)); // [R9]

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin        <= 1'b0;
      freq_point <= 8'h00;
    end
    else if (!comp_on)
    begin
      freq_point <= compare[7:0];
    end
    else if (freq)
    begin
      // frequency output: toggle, then step the next edge by the high byte [R3]
      if (match)
      begin
        pin        <= ~pin;
        freq_point <= freq_point + compare[15:8];
      end
    end
    else if (pwm)
    begin
      // pulse width: 8-bit on the low byte, 16-bit on the full count [R4] [R5]
      if (tick)
      begin
        if (wide)
          pin <= (count < compare);
        else
          pin <= (count[7:0] < compare[7:0]);
      end
      freq_point <= compare[7:0];
    end
    else
    begin
      if (tog && match)
        pin <= ~pin; // [R2]
      freq_point <= compare[7:0];
    end
  end

endmodule

/* File: pcm_consts.vh */
// register map, field positions and reset values of the counter array block
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH

`define PCM_ADDR_CTRL        8'h00
`define PCM_ADDR_COUNT_LO    8'h01
`define PCM_ADDR_COUNT_HI    8'h02
`define PCM_ADDR_FLAGS       8'h03
`define PCM_ADDR_MASK        8'h04
`define PCM_ADDR_MODE_BASE   8'h10
`define PCM_ADDR_CMP_BASE    8'h20

`define PCM_CTRL_RUN         0
`define PCM_CTRL_WDOG_EN     1

`define PCM_MODE_WIDE        7
`define PCM_MODE_COMP        6
`define PCM_MODE_MATCH       3
`define PCM_MODE_TOGGLE      2
`define PCM_MODE_PWM         1
`define PCM_MODE_IRQ         0

`define PCM_CTRL_RESET       8'h00
`define PCM_MODE_RESET       8'h00
`define PCM_CMP_RESET        16'h0000
`define PCM_MASK_RESET       3'h7

`define PCM_TICK_DIV         12
`define PCM_WDT_CHANNEL      2

`endif

/* File: pcm_divider.v */
// timebase divider: one-cycle count enable every DIV clocks
`timescale 1ns/1ps
`include "pcm_consts.vh"
module pcm_divider
#(
  parameter DIV = `PCM_TICK_DIV
)
(
  // clock and reset
  input  wire clk,
  input  wire rst,
  // control
  input  wire enable,
  // output
  output reg  tick
);

  reg [15:0] cnt;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end
    else if (!enable)
    begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end
    else if (cnt == DIV[15:0] - 16'h0001)
    begin
      cnt  <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule

/* File: pcm_properties.sv */
// checker for register port, interrupt and watchdog pulse
`timescale 1ns/1ps
module pcm_properties
#(
  parameter DIV = 12
)
(
  input wire       clk,
  input wire       rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire [2:0] module_output_pin,
  input wire       irq,
  input wire       watchdog_reset
);
  reg       wdog_en;
  reg [7:0] mode2;
  reg [2:0] msk;
  // shadows of what software wrote, lock included
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      wdog_en <= 1'b0;
      mode2   <= 8'h00;
      msk     <= 3'h7;
    end
    else if (wr)
    begin
      if (addr == 8'h00) wdog_en <= wdata[1];
      if (addr == 8'h04) msk <= wdata[2:0];
      if (addr == 8'h12 && !wdog_en) mode2 <= wdata;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_read_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_read_idle: assert property (p_read_idle) else $error("rdata set outside read");
  property p_mask_read; rd && addr == 8'h04 |=> rdata == {5'h00, msk}; endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");
  property p_unmapped; rd && addr == 8'h3F |=> rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mode2_lock; rd && addr == 8'h12 |=> rdata == mode2; endproperty
  a_mode2_lock: assert property (p_mode2_lock) else $error("module two mode wrong");
  property p_irq_mask; irq |-> $past(msk) != 3'h0; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
  property p_irq_off; wr && addr == 8'h04 && wdata == 8'h00 |-> ##2 !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq not masked");
  property p_irq_hold; $fell(irq) |-> $past(wr, 2); endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell on its own");
  property p_wdog_pulse; watchdog_reset |=> !watchdog_reset; endproperty
  a_wdog_pulse: assert property (p_wdog_pulse) else $error("watchdog pulse too long");
  c_irq: cover property ($rose(irq));
  c_wdog: cover property (watchdog_reset);
  c_locked: cover property (wr && addr == 8'h12 && wdog_en);
endmodule
bind pcm_top pcm_properties #(.DIV(DIV)) chk_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .module_output_pin(module_output_pin), .irq(irq), .watchdog_reset(watchdog_reset));

/* File: pcm_top.v */
// counter array with three capture/compare modules, register port and interrupt
`timescale 1ns/1ps
`include "pcm_consts.vh"
// Functional notes
// R1 - match enabled: counter equal to compare sets the module's flag
// R2 - toggle enabled: each match inverts the module output pin
// R3 - toggle plus pulse width together selects frequency output mode
// R4 - pulse width enabled: module pin carries a modulated waveform
// R5 - wide select 0 gives 8-bit modulation, 1 gives 16-bit
// R6 - flag interrupt enable masks the module's flag interrupt
// R7 - watchdog enabled: module two mode writes ignored, module two is watchdog
// R8 - software disables the watchdog before changing module two
// R9 - comparator works only while its comparator enable is set
// R10 - enabled flag drives the interrupt until the flag is cleared
module pcm_top
#(
  parameter NCH = 3,
  parameter DIV = `PCM_TICK_DIV
)
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // module pins
  output reg  [2:0] module_output_pin,
  // events
  output reg        irq,
  output reg        watchdog_reset
);

  // control and status
  reg  [7:0]  counter_array_mode_reg;
  reg  [15:0] count;
  reg  [2:0]  capture_compare_flag;
  reg  [2:0]  irq_mask;
  reg  [7:0]  module_capture_compare_mode [0:2];
  reg  [15:0] compare [0:2];
  reg  [7:0]  next_rdata;
  reg  [2:0]  next_flags;
  wire        tick;
  wire [2:0]  match;
  wire [2:0]  pin;
  wire [2:0]  flag_interrupt_enable;
  wire        run             = counter_array_mode_reg[`PCM_CTRL_RUN];
  wire        watchdog_enable = counter_array_mode_reg[`PCM_CTRL_WDOG_EN];
  wire        wr_flags        = wr && (addr == `PCM_ADDR_FLAGS);
  wire        wdt_hit;
  integer     i;
  // one loop index per process: a shared index would wake the other combinational blocks endlessly
  integer     j;
  integer     k;

  // counter timebase
  pcm_divider
  #(
    .DIV (DIV)
  )
  u_div
  (
    .clk    (clk),
    .rst    (rst),
    .enable (run),
    .tick   (tick)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      assign flag_interrupt_enable[g] = module_capture_compare_mode[g][`PCM_MODE_IRQ];
      // module two is taken over by the watchdog while it is enabled [R7]
      pcm_channel u_ch
      (
        .clk     (clk),
        .rst     (rst),
        .tick    (tick),
        .count   (count),
        .compare (compare[g]),
        .mode    (module_capture_compare_mode[g]),
        .enable  (!(watchdog_enable && (g == `PCM_WDT_CHANNEL))),
        .match   (match[g]),
        .pin     (pin[g])
      );
    end
  endgenerate

  // watchdog fires when the counter high byte reaches module two's high byte [R7]
  assign wdt_hit = watchdog_enable & tick & (count[15:8] == compare[`PCM_WDT_CHANNEL][15:8]);

  // control register and counter
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      counter_array_mode_reg <= `PCM_CTRL_RESET;
      count                  <= 16'h0000;
      irq_mask               <= `PCM_MASK_RESET;
    end
    else
    begin
      if (wr && addr == `PCM_ADDR_CTRL)
        counter_array_mode_reg <= {6'h00, wdata[1:0]};
      if (wr && addr == `PCM_ADDR_MASK)
        irq_mask <= wdata[2:0];
      // a bus write to the count wins over the tick
      if (wr && addr == `PCM_ADDR_COUNT_LO)
        count[7:0] <= wdata;
      else if (wr && addr == `PCM_ADDR_COUNT_HI)
        count[15:8] <= wdata;
      else if (tick)
        count <= count + 16'h0001;
    end
  end

  // mode and compare registers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        module_capture_compare_mode[i] <= `PCM_MODE_RESET;
        compare[i]                     <= `PCM_CMP_RESET;
      end
    end
    else if (wr)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        // software must clear the watchdog enable first; until then module two mode writes drop, compare writes still land [R7] [R8]
        if (addr == `PCM_ADDR_MODE_BASE + i[7:0]
            && !(watchdog_enable && i == `PCM_WDT_CHANNEL))
          module_capture_compare_mode[i] <= wdata; // [R7]
        if (addr == `PCM_ADDR_CMP_BASE + {i[6:0], 1'b0})
          compare[i][7:0] <= wdata;
        if (addr == `PCM_ADDR_CMP_BASE + {i[6:0], 1'b1})
          compare[i][15:8] <= wdata;
      end
    end
  end

  // sticky flags: a match in the clearing cycle survives the clear
  always @*
  begin
    next_flags = capture_compare_flag & ~(wr_flags ? wdata[2:0] : 3'h0);
    for (j = 0; j < 3; j = j + 1)
      if (match[j] && module_capture_compare_mode[j][`PCM_MODE_MATCH])
        next_flags[j] = 1'b1; // [R1]
  end

  // read mux
  always @*
  begin
    next_rdata = 8'h00;
    case (addr)
      `PCM_ADDR_CTRL:     next_rdata = counter_array_mode_reg;
      `PCM_ADDR_COUNT_LO: next_rdata = count[7:0];
      `PCM_ADDR_COUNT_HI: next_rdata = count[15:8];
      `PCM_ADDR_FLAGS:    next_rdata = {5'h00, capture_compare_flag};
      `PCM_ADDR_MASK:     next_rdata = {5'h00, irq_mask};
      default:
      begin
        for (k = 0; k < 3; k = k + 1)
        begin
          if (addr == `PCM_ADDR_MODE_BASE + k[7:0])
            next_rdata = module_capture_compare_mode[k];
          if (addr == `PCM_ADDR_CMP_BASE + {k[6:0], 1'b0})
            next_rdata = compare[k][7:0];
          if (addr == `PCM_ADDR_CMP_BASE + {k[6:0], 1'b1})
            next_rdata = compare[k][15:8];
        end
      end
    endcase
  end

  // registered outputs
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      capture_compare_flag <= 3'h0;
      rdata                <= 8'h00;
      module_output_pin    <= 3'h0;
      irq                  <= 1'b0;
      watchdog_reset       <= 1'b0;
    end
    else
    begin
      capture_compare_flag <= next_flags;
      if (rd)
        rdata <= next_rdata;
      else
        rdata <= 8'h00;
      module_output_pin    <= pin; // [R2] [R4]
      // level held while any enabled flag whose irq_mask bit is set stays set [R6] [R10]
      irq                  <= |(capture_compare_flag & flag_interrupt_enable & irq_mask); // [R6] [R10]
      watchdog_reset       <= wdt_hit; // [R7]
    end
  end

endmodule

/* File: testbench.sv */
// self-checking testbench for the counter array block
`timescale 1ns/1ps
module testbench;
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  wire [7:0] rdata;
  wire [2:0] pin;
  wire       irq;
  wire       wdog;
  integer    error_cnt = 0;
  integer    comparisons = 0;
  integer    i;
  always #50 clk = ~clk;
  // short divider keeps runs brief
  pcm_top #(.DIV(2)) dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .module_output_pin(pin), .irq(irq), .watchdog_reset(wdog));
  task chk(input string n, input [7:0] e, input [7:0] g);
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [7:0] a, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  // compare 5, high byte hi; pin early (count near 2) and late (near 14)
  task t_mode(input [7:0] m, input [7:0] hi, input ep, input lp, input [2:0] fl);
    do_reset;
    wr_reg(8'h20, 8'h05);
    wr_reg(8'h21, hi);
    wr_reg(8'h10, m);
    wr_reg(8'h00, 8'h01);
    repeat (6) @(posedge clk);
    #1 chk("pin early", {7'h00, ep}, {7'h00, pin[0]});
    repeat (24) @(posedge clk);
    #1 chk("pin late", {7'h00, lp}, {7'h00, pin[0]});
    wr_reg(8'h00, 8'h00);
    rd_reg(8'h03, {5'h00, fl});
    $display("mode %h test done", m);
  endtask
  task t_irq;
    t_mode(8'h49, 8'h00, 1'b0, 1'b0, 3'h1);
    chk("irq on", 8'h01, {7'h00, irq});
    wr_reg(8'h04, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("irq masked", 8'h00, {7'h00, irq});
    wr_reg(8'h04, 8'h07);
    repeat (2) @(posedge clk);
    #1 chk("irq unmasked", 8'h01, {7'h00, irq});
    wr_reg(8'h03, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk("irq cleared", 8'h00, {7'h00, irq});
    rd_reg(8'h03, 8'h00);
    $display("irq test done");
  endtask
  task t_wdog;
    do_reset;
    rd_reg(8'h04, 8'h07);
    rd_reg(8'h10, 8'h00);
    rd_reg(8'h00, 8'h00);
    rd_reg(8'h3F, 8'h00);
    wr_reg(8'h12, 8'h48);
    wr_reg(8'h00, 8'h02);
    wr_reg(8'h12, 8'h55);
    rd_reg(8'h12, 8'h48);
    wr_reg(8'h00, 8'h00);
    wr_reg(8'h12, 8'h55);
    rd_reg(8'h12, 8'h55);
    wr_reg(8'h00, 8'h03);
    i = 0;
    while (wdog !== 1'b1 && i < 20)
    begin
      @(posedge clk);
      #1 i = i + 1;
    end
    chk("watchdog", 8'h01, {7'h00, wdog});
    // module two holds toggle on with compare 0; it must stay still while the watchdog owns it
    repeat (2) @(posedge clk);
    #1 chk("pin2 locked", 8'h00, {7'h00, pin[2]});
    $display("watchdog test done");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #500000;
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_mode(8'h09, 8'h00, 1'b0, 1'b0, 3'h0);
    t_mode(8'h41, 8'h00, 1'b0, 1'b0, 3'h0);
    t_mode(8'h44, 8'h00, 1'b0, 1'b1, 3'h0);
    t_mode(8'h46, 8'h10, 1'b0, 1'b1, 3'h0);
    t_mode(8'h42, 8'h01, 1'b1, 1'b0, 3'h0);
    t_mode(8'hC2, 8'h01, 1'b1, 1'b1, 3'h0);
    t_irq;
    t_wdog;
    print_verdict;
  end
endmodule
